/* File: logic/tmr_core.sv */
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`include "tmr_cfg.svh"
// Functional notes
// RULE1 - In continuous mode a written start count only affects the first pass; reloads restart at 0001H.
// RULE2 - Continuous mode counts only prescaled system clock ticks, never the input pin.
// RULE3 - Continuous time-out equals reload value times prescale divided by clock frequency.
// RULE4 - A start count other than 0001H gives a first time-out of the counts from it to reload.
// RULE5 - Counter mode increments on transitions of the timer input pin.
// RULE6 - The input edge polarity bit chooses rising or falling edges in counter mode.
// RULE7 - Counter mode bypasses the prescaler so each qualifying edge counts exactly one.
// RULE8 - The external source keeps the input at most a quarter of the clock, each level two clocks.
// RULE9 - In counter mode reaching reload raises the interrupt, sets count to 0001H and continues.
// RULE10 - With the output function enabled the output pin toggles at every reload.
// RULE11 - Software sets prescale, output level, count, reload, interrupt, pin, and enables last.
// RULE12 - In continuous mode reaching reload also interrupts, restarts at 0001H, toggles output.
// RULE13 - Count and reload are 16 bits in high and low byte registers, compared in full.
module tmr_core #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_in,
  input wire logic timer_out_en,
  output logic timer_out,
  output logic irq
);
  import tmr_pkg::*;

  initial
  begin
    if (ADDR_W < 5 || ADDR_W > 32)
    begin
      $error("ADDR_W out of range");
    end
  end

  // =====================================
  // State
  logic [7:0] ctrl_q;
  tmr_count_t cnt_q;
  tmr_count_t rld_q;
  logic stat_q;
  logic mask_q;
  logic out_q;
  logic in_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rdata_q;
  logic wr_fire;
  logic rd_fire;
  logic run;
  tmr_mode_t mode;
  logic tick;
  logic edge_hit;
  logic step;
  logic reload_ev;
  logic wr_cnth;
  logic wr_cntl;
  logic wr_ctrl;
  logic stat_rd;

  // Word match on all address bits above bit 1, byte lane bits 1:0 ignored
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(off[11:2]));
  endfunction

  assign run = ctrl_q[`TMR_CTRL_EN];
  assign mode = ctrl_q[`TMR_CTRL_MODE] ? TMR_COUNTER : TMR_CONTINUOUS;

  // =====================================
  // AXI4-Lite write path
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;

  // Address and data accepted in either order, held until both are in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    else if (wr_fire)
    begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (wr_fire)
    begin
      w_have_q <= 1'b0;
    end
  end

  // Response one cycle after both halves are in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only lane 0 carries register bits
  assign wr_ctrl = wr_fire && wstrb_q[0] && hit(awaddr_q, `TMR_OFF_CTRL);
  assign wr_cnth = wr_fire && wstrb_q[0] && hit(awaddr_q, `TMR_OFF_CNTH);
  assign wr_cntl = wr_fire && wstrb_q[0] && hit(awaddr_q, `TMR_OFF_CNTL);

  // Control register; software is expected to set enable last
  // RULE11 enable written last
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= `TMR_CTRL_RST;
    end
    else if (wr_ctrl)
    begin
      ctrl_q <= wdata_q[7:0];
    end
  end

  // RULE13 16-bit reload bytes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rld_q <= `TMR_RLD_RST;
    end
    else if (wr_fire && wstrb_q[0])
    begin
      if (hit(awaddr_q, `TMR_OFF_RLDH))
      begin
        rld_q[15:8] <= wdata_q[7:0];
      end
      else if (hit(awaddr_q, `TMR_OFF_RLDL))
      begin
        rld_q[7:0] <= wdata_q[7:0];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mask_q <= 1'b0;
    end
    else if (wr_fire && wstrb_q[0] && hit(awaddr_q, `TMR_OFF_MASK))
    begin
      mask_q <= wdata_q[0];
    end
  end

  // =====================================
  // Count sources
  tmr_prescaler u_pres (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run && mode == TMR_CONTINUOUS),
    .sel(ctrl_q[`TMR_CTRL_PRES_HI:`TMR_CTRL_PRES_LO]),
    .tick(tick)
  );

  // Previous input level; pin is taken as synchronous already
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_q <= 1'b0;
    end
    else
    begin
      in_q <= timer_in;
    end
  end

  // RULE6 polarity selects edge
  assign edge_hit = ctrl_q[`TMR_CTRL_POL] ? (in_q && !timer_in) : (!in_q && timer_in);

  // RULE2 prescaled clock only; RULE5 RULE7 raw edges, prescaler bypassed
  // RULE8 source spacing assumed so no edge falls between samples
  always_comb
  begin
    step = 1'b0;
    unique case (mode)
      TMR_CONTINUOUS: step = run && tick;
      TMR_COUNTER: step = run && edge_hit;
    endcase
  end

  // RULE13 full 16-bit compare; RULE3 RULE4 period from start to reload
  assign reload_ev = step && (cnt_q == rld_q);

  // RULE1 RULE9 RULE12 restart at 0001H after every reload, except when a count byte write lands in the same cycle and wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= `TMR_CNT_RST;
    end
    else if (wr_cnth)
    begin
      cnt_q[15:8] <= wdata_q[7:0];
    end
    else if (wr_cntl)
    begin
      cnt_q[7:0] <= wdata_q[7:0];
    end
    else if (reload_ev)
    begin
      cnt_q <= `TMR_RESTART;
    end
    else if (step)
    begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // RULE10 toggle at reload; only with pin function and toggle bit both on
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_q <= 1'b0;
    end
    else if (wr_ctrl && !wdata_q[`TMR_CTRL_EN])
    begin
      out_q <= wdata_q[`TMR_CTRL_OUTLVL];
    end
    else if (reload_ev && ctrl_q[`TMR_CTRL_OUTEN] && timer_out_en)
    begin
      out_q <= !out_q;
    end
  end

  assign timer_out = out_q;

  // =====================================
  // Interrupt status, cleared by read, set wins
  assign stat_rd = rd_fire && hit(s_axi_araddr, `TMR_OFF_STAT);

  // RULE9 RULE12 reload raises interrupt
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_q <= 1'b0;
    end
    else if (reload_ev)
    begin
      stat_q <= 1'b1;
    end
    else if (stat_rd)
    begin
      stat_q <= 1'b0;
    end
  end

  assign irq = stat_q && mask_q;

  // =====================================
  // AXI4-Lite read path
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;
  assign s_axi_rresp = 2'b00;
  assign s_axi_rdata = rdata_q;

  // Unmapped words read zero with OKAY
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (rd_fire)
    begin
      rdata_q <= 32'h0000_0000;
      if (hit(rd_addr, `TMR_OFF_CTRL))
      begin
        rdata_q[7:0] <= ctrl_q;
      end
      else if (hit(rd_addr, `TMR_OFF_CNTH))
      begin
        rdata_q[7:0] <= cnt_q[15:8];
      end
      else if (hit(rd_addr, `TMR_OFF_CNTL))
      begin
        rdata_q[7:0] <= cnt_q[7:0];
      end
      else if (hit(rd_addr, `TMR_OFF_RLDH))
      begin
        rdata_q[7:0] <= rld_q[15:8];
      end
      else if (hit(rd_addr, `TMR_OFF_RLDL))
      begin
        rdata_q[7:0] <= rld_q[7:0];
      end
      else if (hit(rd_addr, `TMR_OFF_STAT))
      begin
        rdata_q[0] <= stat_q || reload_ev;
        rdata_q[1] <= out_q;
      end
      else if (hit(rd_addr, `TMR_OFF_MASK))
      begin
        rdata_q[0] <= mask_q;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* File: shared/tmr_cfg.svh */
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
// =====================================
// Register byte offsets
`define TMR_OFF_CTRL 12'h000
`define TMR_OFF_CNTH 12'h004
`define TMR_OFF_CNTL 12'h008
`define TMR_OFF_RLDH 12'h00c
`define TMR_OFF_RLDL 12'h010
`define TMR_OFF_STAT 12'h014
`define TMR_OFF_MASK 12'h018
// =====================================
// Control field positions
`define TMR_CTRL_EN 0
`define TMR_CTRL_MODE 1
`define TMR_CTRL_POL 2
`define TMR_CTRL_OUTEN 3
`define TMR_CTRL_OUTLVL 4
`define TMR_CTRL_PRES_LO 5
`define TMR_CTRL_PRES_HI 7
// =====================================
// Reset values and the count restart value
`define TMR_CTRL_RST 8'h00
`define TMR_CNT_RST 16'h0001
`define TMR_RLD_RST 16'hffff
`define TMR_RESTART 16'h0001
`endif

/* File: shared/tmr_pkg.sv */
package tmr_pkg;
  // =====================================
  // Counting modes
  typedef enum logic [1:0] {
    TMR_CONTINUOUS = 2'b01,
    TMR_COUNTER = 2'b10
  } tmr_mode_t;
  typedef logic [15:0] tmr_count_t;
endpackage

/* File: logic/tmr_prescaler.sv */
`timescale 1ns/10ps
// =====================================
// Prescaler: one-cycle tick every 2^sel system clocks
module tmr_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);
  logic [6:0] div_q;
  logic [6:0] lim;

  // Terminal count is 2^sel - 1
  assign lim = 7'((8'h01 << sel) - 8'h01);

  // Free divider, held cleared while stopped so each start is exact
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      div_q <= 7'h00;
    end
    else if (div_q >= lim)
    begin
      div_q <= 7'h00;
    end
    else
    begin
      div_q <= div_q + 7'h01;
    end
  end

  assign tick = run && (div_q >= lim);
endmodule

/* File: dv/tmr_src_model.sv */
`timescale 1ns/10ps
// =====================================
// Pulse source on the timer input pin
module tmr_src_model (
  input wire logic aclk,
  output logic timer_in
);
  initial timer_in = 1'b0;
  task automatic drive(input logic v);
    @(posedge aclk);
    timer_in <= v;
    repeat (3) @(posedge aclk);
  endtask
  // Toggles n times, each level kept long enough to be seen
  task automatic burst(input int n);
    repeat (n) drive(~timer_in);
  endtask
endmodule

/* File: dv/tmr_core_asserts.sv */
`timescale 1ns/10ps
// =====================================
// Port checker for the timer core
module tmr_core_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_out,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves taken at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (wr_taken |=> ##1 s_axi_bvalid)
    else $error("write response not two cycles after request");
  AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data not one cycle after request");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  AST_B_OKAY: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
    else $error("write response not okay");
  AST_R_OKAY: assert property (s_axi_rvalid |-> s_axi_rresp == 2'b00)
    else $error("read response not okay");
  AST_AR_BLOCK: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_RESET_QUIET: assert property ($rose(aresetn) |-> !irq && !timer_out && !s_axi_bvalid)
    else $error("outputs not idle after reset");
endmodule

bind tmr_core tmr_core_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_out(timer_out), .irq(irq));

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
`include "tmr_cfg.svh"
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic timer_in, timer_out_en, timer_out, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int mismatches, samples_checked, cyc;
  tmr_core u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timer_in(timer_in), .timer_out_en(timer_out_en),
    .timer_out(timer_out), .irq(irq));
  tmr_src_model u_src (.aclk(aclk), .timer_in(timer_in));
  // =====================================
  // Clock and hang guard
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches = mismatches + 1;
      summarize();
    end
  end
  // =====================================
  // Reporting
  task automatic summarize;
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // =====================================
  // Bus master; every handshake is judged at the rising edge that takes it
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1)
      begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1)
      begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] v;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk(nm, exp, v);
  endtask
  // Bounded wait for the interrupt level, returns the cycle stamp
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (irq !== 1'b1 && n < 100);
    t = cyc;
    chk("irq_wait", 32'h1, irq);
  endtask
  // =====================================
  // Scenarios
  task automatic t_reset;
    rdc(`TMR_OFF_CTRL, 32'h0, "ctrl");
    rdc(`TMR_OFF_CNTL, 32'h1, "count_lo");
    rdc(`TMR_OFF_RLDH, 32'hff, "reload_hi");
    rdc(`TMR_OFF_RLDL, 32'hff, "reload_lo");
    rdc(`TMR_OFF_MASK, 32'h0, "mask");
    // Lane 0 off: the write must be dropped
    s_axi_wstrb <= 4'he;
    wr(`TMR_OFF_MASK, 8'h01);
    s_axi_wstrb <= 4'hf;
    rdc(`TMR_OFF_MASK, 32'h0, "mask_lane_off");
    wr(12'h01c, 8'h5a);
    rdc(12'h01c, 32'h0, "unmapped");
  endtask
  task automatic t_continuous;
    int t0, t1, t2;
    // level, irq, reload, count, enable last
    wr(`TMR_OFF_CTRL, 8'h10);
    chk("out_init", 32'h1, timer_out);
    wr(`TMR_OFF_MASK, 8'h01);
    wr(`TMR_OFF_RLDH, 8'h00);
    wr(`TMR_OFF_RLDL, 8'h05);
    wr(`TMR_OFF_CNTH, 8'h00);
    wr(`TMR_OFF_CNTL, 8'h04);
    t0 = cyc;
    wr(`TMR_OFF_CTRL, 8'h39);
    wait_irq(t1);
    chk("first_pass", 32'h1, (t1 - t0) >= 4 && (t1 - t0) < 10);
    chk("out_toggle", 32'h0, timer_out);
    rdc(`TMR_OFF_STAT, 32'h1, "stat_first");
    wait_irq(t1);
    rdc(`TMR_OFF_STAT, 32'h3, "stat_second");
    fork
      u_src.burst(6);
      wait_irq(t2);
    join
    chk("period", 32'd10, t2 - t1);
    wr(`TMR_OFF_CTRL, 8'h00);
  endtask
  task automatic t_counter;
    wr(`TMR_OFF_CNTL, 8'h01);
    wr(`TMR_OFF_RLDL, 8'h03);
    wr(`TMR_OFF_STAT, 8'h00);
    rdc(`TMR_OFF_STAT, 32'h1, "stat_left");
    // Toggle bit on but pin function off: output must stay put
    timer_out_en <= 1'b0;
    wr(`TMR_OFF_CTRL, 8'heb);
    u_src.drive(1'b1);
    rdc(`TMR_OFF_CNTL, 32'h2, "rise_count");
    u_src.drive(1'b0);
    rdc(`TMR_OFF_CNTL, 32'h2, "fall_ignored");
    u_src.drive(1'b1);
    u_src.drive(1'b0);
    u_src.drive(1'b1);
    chk("irq_reload", 32'h1, irq);
    chk("out_gated", 32'h0, timer_out);
    rdc(`TMR_OFF_CNTL, 32'h1, "restart");
    wr(`TMR_OFF_MASK, 8'h00);
    chk("irq_masked", 32'h0, irq);
    wr(`TMR_OFF_MASK, 8'h01);
    chk("irq_unmasked", 32'h1, irq);
    rdc(`TMR_OFF_STAT, 32'h1, "stat_counter");
    chk("irq_cleared", 32'h0, irq);
    u_src.drive(1'b0);
    wr(`TMR_OFF_CTRL, 8'he7);
    u_src.drive(1'b1);
    rdc(`TMR_OFF_CNTL, 32'h1, "rise_ignored");
    u_src.drive(1'b0);
    rdc(`TMR_OFF_CNTL, 32'h2, "fall_count");
  endtask
  // =====================================
  // Main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    timer_out_en = 1'b1;
    cyc = 0;
    mismatches = 0;
    samples_checked = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_continuous();
    t_counter();
    summarize();
  end
endmodule
